// file: logic/bcw_decoder.sv
// Boot configuration word decoder: captures the word at reset and drives flash, CPU and debug controls.
// Functional notes
// [R01] Flash sleep power bit 1 powers the flash down in Sleep, 0 keeps it powered.
// [R02] Each device reset copies the two-bit flash ECC setting into the runtime ECC field at bits 5:4.
// [R03] ECC setting 11 disables ECC and dynamic ECC and leaves the runtime field writable.
// [R04] Setting 10 disables ECC with the field locked; 01 enables dynamic ECC with the field locked.
// [R05] Setting 00 enables ECC, locks the field and blocks single-word flash programming.
// [R06] Boot ISA bit 1 selects the standard set: exception flag 0 and ISA field 10.
// [R07] Boot ISA bit 0 selects the compressed set: exception flag 1 and ISA field 11.
// [R08] The trace bit enables CPU trace when 1 and disables it when 0.
// [R09] Debug channel select 11 picks pair one, 10 picks pair two, 01 and 00 are reserved.
// [R10] The test port bit enables the port and loads the runtime test port enable bit.
// [R11] The debugger is disabled when the upper debug bit is 1 and enabled when it is 0.
// [R12] Code protection forces the debug field to 11 so the debugger stays off.
// [R13] Decoded values are captured once at reset and held until the next reset; test_port_enable_ff and the unlocked ECC field follow ADDR_ECC_CTRL writes.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bcw_decoder
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Configuration storage.
   input wire logic [31:0] device_config_word0,
   input wire logic code_protect,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_ff,
   // Flash controls.
   output logic flash_sleep_powerdown_ff,
   output logic [1:0] runtime_ecc_control_ff,
   output logic ecc_enable_ff,
   output logic dyn_ecc_enable_ff,
   output logic word_prog_block_ff,
   // CPU controls.
   output logic exception_isa_flag_ff,
   output logic [1:0] cpu_isa_field_ff,
   output logic trace_enable_ff,
   // Debug controls.
   output logic programming_pair_one_ff,
   output logic programming_pair_two_ff,
   output logic ice_sel_reserved_ff,
   output logic test_port_enable_ff,
   output logic debugger_enable_ff,
   // Status.
   output logic config_valid_ff
);

   // ************************************************************
   // Capture of the configuration word.
   // ************************************************************
   typedef enum logic [0:0] {ST_CAPTURE, ST_RUN} bcw_state_t;
   bcw_state_t state_ff;
   bcw_state_t nxt_state;
   logic [31:0] cfg_ff;
   logic [31:0] nxt_cfg;
   logic rt_test_port_ff;
   logic nxt_rt_test_port;
   wire logic capture = (state_ff == ST_CAPTURE);
   wire logic [31:0] cfg_eff = capture ? nxt_cfg : cfg_ff;

   always_comb
   begin
      unique case (state_ff)
         ST_CAPTURE: nxt_state = ST_RUN;
         ST_RUN: nxt_state = ST_RUN;
      endcase
   end

   // Code protection overrides whatever debug code was stored.
   assign nxt_cfg = capture ?
                    {device_config_word0[31:2],
                     code_protect ? bcw_pkg::DBG_FORCED : device_config_word0[1:0]} : // [R12]
                    cfg_ff; // [R13]

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= ST_CAPTURE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_ff <= bcw_pkg::RST_CFG_WORD;
      end
      else
      begin
         cfg_ff <= nxt_cfg; // [R13]
      end
   end

   // ************************************************************
   // Register decode.
   // ************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire logic wr_ecc = reg_wr && hit(reg_addr, bcw_pkg::ADDR_ECC_CTRL);
   wire logic ecc_locked;
   logic [1:0] rt_ecc;

   bcw_ecc_ctrl u_ecc
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .load(capture), // [R02]
      .boot_setting(cfg_eff[bcw_pkg::POS_ECC_HI:bcw_pkg::POS_ECC_LO]),
      .sw_we(wr_ecc), // [R03] [R04] [R05]
      .sw_data(reg_wdata[bcw_pkg::POS_RT_ECC_LO+1:bcw_pkg::POS_RT_ECC_LO]),
      .runtime_ecc_control_ff(rt_ecc),
      .locked_ff(ecc_locked)
   );

   // Runtime test port bit follows the word at reset and is software writable afterwards.
   assign nxt_rt_test_port = capture ? cfg_eff[bcw_pkg::POS_TEST_PORT] : // [R10]
                             wr_ecc ? reg_wdata[bcw_pkg::POS_RT_TEST_PORT] : rt_test_port_ff;

   wire logic [31:0] sys_cfg_word = {26'h0, rt_ecc, rt_test_port_ff, 3'h0};
   wire logic [31:0] status_word = {30'h0, ecc_locked, !capture};
   wire logic [31:0] rd_mux = hit(reg_addr, bcw_pkg::ADDR_CFG_WORD) ? cfg_ff :
                              hit(reg_addr, bcw_pkg::ADDR_ECC_CTRL) ? sys_cfg_word :
                              hit(reg_addr, bcw_pkg::ADDR_STATUS) ? status_word : 32'h0;

   // ************************************************************
   // Decoded controls.
   // ************************************************************
   wire logic isa_flag;
   wire logic [1:0] isa_field;

   bcw_isa_decode u_isa
   (
      .boot_instruction_set_select(cfg_eff[bcw_pkg::POS_BOOT_INSTRUCTION_SET_SELECT]), // [R06] [R07]
      .exception_isa_flag(isa_flag),
      .cpu_isa_field(isa_field)
   );

   wire logic [1:0] ecc_set = cfg_eff[bcw_pkg::POS_ECC_HI:bcw_pkg::POS_ECC_LO];
   wire logic [1:0] ice_set = cfg_eff[bcw_pkg::POS_ICE_HI:bcw_pkg::POS_ICE_LO];
   wire logic nxt_ecc_en = (ecc_set == bcw_pkg::ECC_FULL); // [R05]
   wire logic nxt_dyn_en = (ecc_set == bcw_pkg::ECC_DYNAMIC); // [R04]
   wire logic nxt_pair1 = (ice_set == bcw_pkg::ICE_PAIR_ONE); // [R09]
   wire logic nxt_pair2 = (ice_set == bcw_pkg::ICE_PAIR_TWO); // [R09]

   // ************************************************************
   // Output registers, one short process for each control.
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata_ff <= 32'h0;
      end
      else
      begin
         reg_rdata_ff <= reg_rd ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rt_test_port_ff <= 1'b0;
      end
      else
      begin
         rt_test_port_ff <= nxt_rt_test_port; // [R10]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         flash_sleep_powerdown_ff <= 1'b0;
      end
      else
      begin
         flash_sleep_powerdown_ff <= cfg_eff[bcw_pkg::POS_FLASH_SLEEP_POWERDOWN]; // [R01]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         runtime_ecc_control_ff <= bcw_pkg::RST_RT_ECC;
      end
      else
      begin
         runtime_ecc_control_ff <= rt_ecc; // [R02]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ecc_enable_ff <= 1'b0;
      end
      else
      begin
         ecc_enable_ff <= nxt_ecc_en; // [R03] [R05]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dyn_ecc_enable_ff <= 1'b0;
      end
      else
      begin
         dyn_ecc_enable_ff <= nxt_dyn_en; // [R04]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         word_prog_block_ff <= 1'b0;
      end
      else
      begin
         word_prog_block_ff <= nxt_ecc_en; // [R05]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         exception_isa_flag_ff <= 1'b0;
      end
      else
      begin
         exception_isa_flag_ff <= isa_flag; // [R06] [R07]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cpu_isa_field_ff <= bcw_pkg::ISA_STANDARD;
      end
      else
      begin
         cpu_isa_field_ff <= isa_field; // [R06] [R07]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         trace_enable_ff <= 1'b0;
      end
      else
      begin
         trace_enable_ff <= cfg_eff[bcw_pkg::POS_TRACE]; // [R08]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         programming_pair_one_ff <= 1'b0;
      end
      else
      begin
         programming_pair_one_ff <= nxt_pair1; // [R09]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         programming_pair_two_ff <= 1'b0;
      end
      else
      begin
         programming_pair_two_ff <= nxt_pair2; // [R09]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ice_sel_reserved_ff <= 1'b0;
      end
      else
      begin
         ice_sel_reserved_ff <= !nxt_pair1 && !nxt_pair2; // [R09]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         test_port_enable_ff <= 1'b0;
      end
      else
      begin
         test_port_enable_ff <= nxt_rt_test_port; // [R10]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         debugger_enable_ff <= 1'b0;
      end
      else
      begin
         debugger_enable_ff <= !cfg_eff[bcw_pkg::POS_DBG_HI]; // [R11]
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         config_valid_ff <= 1'b0;
      end
      else
      begin
         config_valid_ff <= 1'b1;
      end
   end

endmodule : bcw_decoder
`default_nettype wire

// file: include/bcw_pkg.sv
// Package of offsets, field positions and codes for the boot configuration word decoder.
package bcw_pkg;

   // ************************************************************
   // Register offsets.
   // ************************************************************
   localparam logic [7:0] ADDR_CFG_WORD = 8'h00;
   localparam logic [7:0] ADDR_ECC_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // ************************************************************
   // Configuration word field positions.
   // ************************************************************
   localparam int POS_FLASH_SLEEP_POWERDOWN = 10;
   localparam int POS_ECC_HI = 9;
   localparam int POS_ECC_LO = 8;
   localparam int POS_RSVD = 7;
   localparam int POS_BOOT_INSTRUCTION_SET_SELECT = 6;
   localparam int POS_TRACE = 5;
   localparam int POS_ICE_HI = 4;
   localparam int POS_ICE_LO = 3;
   localparam int POS_TEST_PORT = 2;
   localparam int POS_DBG_HI = 1;
   localparam int POS_DBG_LO = 0;

   // ************************************************************
   // System configuration register field positions.
   // ************************************************************
   localparam int POS_RT_ECC_LO = 4;
   localparam int POS_RT_TEST_PORT = 3;

   // ************************************************************
   // Codes.
   // ************************************************************
   localparam logic [1:0] ECC_OFF_WRITABLE = 2'h3;
   localparam logic [1:0] ECC_OFF_LOCKED = 2'h2;
   localparam logic [1:0] ECC_DYNAMIC = 2'h1;
   localparam logic [1:0] ECC_FULL = 2'h0;
   localparam logic [1:0] ISA_STANDARD = 2'h2;
   localparam logic [1:0] ISA_COMPRESSED = 2'h3;
   localparam logic [1:0] ICE_PAIR_ONE = 2'h3;
   localparam logic [1:0] ICE_PAIR_TWO = 2'h2;
   localparam logic [1:0] DBG_FORCED = 2'h3;

   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam logic [31:0] RST_CFG_WORD = 32'hffff_ffff;
   localparam logic [1:0] RST_RT_ECC = 2'h3;

endpackage : bcw_pkg

// file: logic/bcw_ecc_ctrl.sv
// Runtime flash ECC control field with boot load and lock.
`timescale 1ns/1ps
`default_nettype none
module bcw_ecc_ctrl
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Boot load.
   input wire logic load,
   input wire logic [1:0] boot_setting,
   // Software write.
   input wire logic sw_we,
   input wire logic [1:0] sw_data,
   // State.
   output logic [1:0] runtime_ecc_control_ff,
   output logic locked_ff
);

   logic [1:0] nxt_runtime_ecc_control;
   logic nxt_locked;
   wire logic boot_unlocked = (boot_setting == bcw_pkg::ECC_OFF_WRITABLE);

   assign nxt_locked = load ? !boot_unlocked : locked_ff;
   assign nxt_runtime_ecc_control = load ? boot_setting :
                                    (sw_we && !locked_ff) ? sw_data : runtime_ecc_control_ff;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         runtime_ecc_control_ff <= bcw_pkg::RST_RT_ECC;
         locked_ff <= 1'b0;
      end
      else
      begin
         runtime_ecc_control_ff <= nxt_runtime_ecc_control;
         locked_ff <= nxt_locked;
      end
   end

endmodule : bcw_ecc_ctrl
`default_nettype wire

// file: logic/bcw_isa_decode.sv
// Boot instruction set decode towards the CPU configuration register three.
`timescale 1ns/1ps
`default_nettype none
module bcw_isa_decode
(
   // Input.
   input wire logic boot_instruction_set_select,
   // Outputs.
   output logic exception_isa_flag,
   output logic [1:0] cpu_isa_field
);

   assign exception_isa_flag = !boot_instruction_set_select;
   assign cpu_isa_field = boot_instruction_set_select ? bcw_pkg::ISA_STANDARD : bcw_pkg::ISA_COMPRESSED;

endmodule : bcw_isa_decode
`default_nettype wire

// file: test/bcw_decoder_props.sv
// Checker of the decoder outputs against the captured configuration word.
`timescale 1ns/1ps
`default_nettype none
module bcw_decoder_props
(
   // Watched ports.
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [31:0] device_config_word0,
   input wire logic code_protect,
   input wire logic flash_sleep_powerdown_ff,
   input wire logic [1:0] runtime_ecc_control_ff,
   input wire logic ecc_enable_ff,
   input wire logic dyn_ecc_enable_ff,
   input wire logic word_prog_block_ff,
   input wire logic exception_isa_flag_ff,
   input wire logic [1:0] cpu_isa_field_ff,
   input wire logic trace_enable_ff,
   input wire logic programming_pair_one_ff,
   input wire logic programming_pair_two_ff,
   input wire logic ice_sel_reserved_ff,
   input wire logic test_port_enable_ff,
   input wire logic debugger_enable_ff,
   input wire logic config_valid_ff
);
   logic [31:0] cap_ff;
   logic cp_ff;
   wire logic v = config_valid_ff;
   wire logic [1:0] e = cap_ff[9:8];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // A private copy of the word taken at the same edge as the design's capture.
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn) {cp_ff, cap_ff} <= 33'h0;
      else if (!v) {cp_ff, cap_ff} <= {code_protect, device_config_word0};
   flash_sleep_powerdown_map_a: assert property (v |-> flash_sleep_powerdown_ff == cap_ff[10]) else $error("Sleep bit wrong.");
   ecc_load_a: assert property ($rose(v) |=> runtime_ecc_control_ff == e) else $error("ECC load wrong.");
   ecc_modes_a: assert property (v |-> {ecc_enable_ff, dyn_ecc_enable_ff, word_prog_block_ff} ==
      {e == 2'h0, e == 2'h1, e == 2'h0}) else $error("ECC mode wrong.");
   ecc_lock_a: assert property (v && $past(v, 2) && e != 2'h3 |-> $stable(runtime_ecc_control_ff))
      else $error("Locked ECC field moved.");
   isa_map_a: assert property (v |-> {exception_isa_flag_ff, cpu_isa_field_ff} == (cap_ff[6] ? 3'h2 : 3'h7))
      else $error("ISA wrong.");
   trace_map_a: assert property (v |-> trace_enable_ff == cap_ff[5]) else $error("Trace wrong.");
   ice_map_a: assert property (v |-> {programming_pair_one_ff, programming_pair_two_ff, ice_sel_reserved_ff} ==
      {cap_ff[4:3] == 2'h3, cap_ff[4:3] == 2'h2, !cap_ff[4]}) else $error("Channel select wrong.");
   tport_load_a: assert property ($rose(v) |-> test_port_enable_ff == cap_ff[2]) else $error("Test port wrong.");
   dbg_map_a: assert property (v |-> debugger_enable_ff == !(cap_ff[1] || cp_ff)) else $error("Debug wrong.");
endmodule : bcw_decoder_props
bind bcw_decoder bcw_decoder_props chk (.core_clk(core_clk), .rstn(rstn), .device_config_word0(device_config_word0),
   .code_protect(code_protect), .flash_sleep_powerdown_ff(flash_sleep_powerdown_ff),
   .runtime_ecc_control_ff(runtime_ecc_control_ff), .ecc_enable_ff(ecc_enable_ff),
   .dyn_ecc_enable_ff(dyn_ecc_enable_ff), .word_prog_block_ff(word_prog_block_ff),
   .exception_isa_flag_ff(exception_isa_flag_ff), .cpu_isa_field_ff(cpu_isa_field_ff),
   .trace_enable_ff(trace_enable_ff), .programming_pair_one_ff(programming_pair_one_ff),
   .programming_pair_two_ff(programming_pair_two_ff), .ice_sel_reserved_ff(ice_sel_reserved_ff),
   .test_port_enable_ff(test_port_enable_ff), .debugger_enable_ff(debugger_enable_ff),
   .config_valid_ff(config_valid_ff));
`default_nettype wire

// file: test/bcw_nvm_model.sv
// Nonvolatile configuration storage model that feeds the decoder.
`timescale 1ns/1ps
`default_nettype none
module bcw_nvm_model
(
   // Clock and programming.
   input wire logic core_clk,
   input wire logic prog_en,
   input wire logic [31:0] prog_word,
   input wire logic prog_cp,
   // Stored values.
   output logic [31:0] device_config_word0,
   output logic code_protect
);
   // Erased word cells read as ones and code protection reads as zero until programmed.
   initial {code_protect, device_config_word0} = 33'h0_ffff_ffff;
   always @(posedge core_clk)
      if (prog_en) {code_protect, device_config_word0} <= {prog_cp, prog_word};
endmodule : bcw_nvm_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench of the boot configuration word decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic prog_en = 1'b0;
   logic prog_cp = 1'b0;
   logic [31:0] prog_word = 32'hffff_ffff;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   wire logic [31:0] word;
   wire logic cp;
   logic [31:0] rdata;
   logic [1:0] rte, isa;
   logic fsp, eccen, dyn, wpb, exf, trc, p1, p2, ires, tpe, dbe, cvld;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   always #5 core_clk = ~core_clk;
   bcw_nvm_model nvm (.core_clk(core_clk), .prog_en(prog_en), .prog_word(prog_word), .prog_cp(prog_cp),
      .device_config_word0(word), .code_protect(cp));
   bcw_decoder dut (.core_clk(core_clk), .rstn(rstn), .device_config_word0(word), .code_protect(cp),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
      .flash_sleep_powerdown_ff(fsp), .runtime_ecc_control_ff(rte), .ecc_enable_ff(eccen),
      .dyn_ecc_enable_ff(dyn), .word_prog_block_ff(wpb), .exception_isa_flag_ff(exf), .cpu_isa_field_ff(isa),
      .trace_enable_ff(trc), .programming_pair_one_ff(p1), .programming_pair_two_ff(p2),
      .ice_sel_reserved_ff(ires), .test_port_enable_ff(tpe), .debugger_enable_ff(dbe), .config_valid_ff(cvld));
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic do_reset(input logic [31:0] w, input logic c);
      @(posedge core_clk);
      prog_word <= w;
      prog_cp <= c;
      prog_en <= 1'b1;
      rstn <= 1'b0;
      repeat (4) @(posedge core_clk);
      prog_en <= 1'b0;
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask : do_reset
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic test_decode(input logic [31:0] w, input logic c);
      logic [31:0] d;
      do_reset(w, c);
      #1 chk("sleep", fsp, w[10]);
      chk("rt_ecc", rte, w[9:8]);
      chk("ecc_mode", {eccen, dyn, wpb}, {w[9:8] == 2'h0, w[9:8] == 2'h1, w[9:8] == 2'h0});
      chk("isa", {exf, isa}, w[6] ? 3'h2 : 3'h7);
      chk("trace", trc, w[5]);
      chk("ice", {p1, p2, ires}, {w[4:3] == 2'h3, w[4:3] == 2'h2, !w[4]});
      chk("tport", tpe, w[2]);
      chk("dbg", dbe, !(w[1] || c));
      chk("valid", cvld, 1'b1);
      rd(bcw_pkg::ADDR_CFG_WORD, d);
      chk("cfg_rd", d, w | {30'h0, c, c});
      rd(bcw_pkg::ADDR_STATUS, d);
      chk("status", d, {30'h0, w[9:8] != 2'h3, 1'b1});
      $display("test_decode %h done", w);
   endtask : test_decode
   task automatic test_ecc_write;
      logic [31:0] d;
      do_reset(32'hffff_ffff, 1'b0);
      wr(bcw_pkg::ADDR_ECC_CTRL, 32'h10);
      rd(bcw_pkg::ADDR_ECC_CTRL, d);
      chk("ecc_wr_rt", rte, 2'h1);
      chk("ecc_wr_tport", tpe, 1'b0);
      chk("ecc_wr_rd", d, 32'h10);
      do_reset(32'hffff_fefb, 1'b0);
      wr(bcw_pkg::ADDR_ECC_CTRL, 32'h08);
      rd(bcw_pkg::ADDR_ECC_CTRL, d);
      chk("ecc_lock_rt", rte, 2'h2);
      chk("ecc_lock_tport", tpe, 1'b1);
      chk("ecc_lock_rd", d, 32'h28);
      $display("test_ecc_write done");
   endtask : test_ecc_write
   task automatic test_hold(input logic [31:0] w);
      logic [31:0] d;
      do_reset(w, 1'b0);
      prog_word <= ~w;
      prog_en <= 1'b1;
      @(posedge core_clk);
      prog_en <= 1'b0;
      wr(bcw_pkg::ADDR_CFG_WORD, 32'h0);
      rd(bcw_pkg::ADDR_CFG_WORD, d);
      chk("hold_trace", trc, w[5]);
      chk("hold_isa", isa, w[6] ? 2'h2 : 2'h3);
      chk("hold_rd", d, w);
      rd(8'h0c, d);
      chk("unmapped", d, 32'h0);
      $display("test_hold done");
   endtask : test_hold
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_total++;
         give_verdict;
      end
   end
   initial
   begin
      test_decode(32'hffff_ffff, 1'b0);
      test_decode(32'hffff_fa91, 1'b0);
      test_decode(32'hffff_fdec, 1'b1);
      test_decode(32'hffff_f8a2, 1'b0);
      test_ecc_write;
      test_hold(32'hffff_fa91);
      give_verdict;
   end
endmodule : tb_top
`default_nettype wire
